//--- core/hserr_pkg.sv
package hserr_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // Register indices on the plain register port.
   localparam logic [2:0] OFS_CMD = 3'h0;
   localparam logic [2:0] OFS_MODE = 3'h1;
   localparam logic [2:0] OFS_INMODE = 3'h2;
   localparam logic [2:0] OFS_CFG = 3'h3;
   localparam logic [2:0] OFS_MAIN = 3'h4;
   localparam logic [2:0] OFS_ST1 = 3'h5;
   localparam logic [2:0] OFS_ST2 = 3'h6;

   // Command codes written to the command register.
   localparam logic [7:0] CMD_CLR_STATUS = 8'h25;
   localparam logic [7:0] CMD_DEC_STOP = 8'h26;
   localparam logic [7:0] CMD_INST_STOP = 8'h27;
   localparam logic [7:0] CMD_SEARCH = 8'h62;
   localparam logic [7:0] CMD_DRIVE_LO = 8'h20;
   localparam logic [7:0] CMD_DRIVE_HI = 8'h23;

   // Search mode register fields.
   localparam int MODE_PCLR = 8;
   localparam logic [15:0] MODE_RST = 16'h0000;

   // Input mode register polarity bits, one means active high.
   localparam int POL_NEAR = 2;
   localparam int POL_ORIGIN = 4;
   localparam int POL_INDEX = 7;
   localparam logic [15:0] INMODE_RST = 16'h0000;

   // Configuration register: bit zero selects instant stop on a limit.
   localparam int CFG_LIM_INST = 0;
   localparam logic [15:0] CFG_RST = 16'h0000;

   // Status field positions.
   localparam int MAIN_ERR = 4;
   localparam int MAIN_BUSY = 8;
   localparam int ST2_PLUS = 2;
   localparam int ST2_MINUS = 3;
   localparam int ST2_ALARM = 4;
   localparam int ST2_EMG = 5;
   localparam int ST2_INDEX = 7;
   localparam int ST2_EXEC_LO = 8;
   localparam int ST1_PLUS = 12;
   localparam int ST1_MINUS = 13;
   localparam int ST1_ALARM = 14;
   localparam int ST1_EMG = 15;

   // Search execution state codes.
   localparam logic [4:0] EX_IDLE = 5'h00;
   localparam logic [4:0] EX_S1 = 5'h03;
   localparam logic [4:0] EX_S2_REV_FIND = 5'h08;
   localparam logic [4:0] EX_S2_REV_LEAVE = 5'h0C;
   localparam logic [4:0] EX_S2_FIND = 5'h0F;
   localparam logic [4:0] EX_S3 = 5'h14;
   localparam logic [4:0] EX_S4 = 5'h19;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_S1,
      ST_S2_REV_FIND,
      ST_S2_REV_LEAVE,
      ST_S2_FIND,
      ST_S3,
      ST_S4,
      ST_STOPPING
   } hserr_state_e;

   // Raw sensor pins of one axis.
   typedef struct packed {
      logic alarm;
      logic emergency_stop_input;
      logic plus_overrun_limit;
      logic minus_overrun_limit;
      logic near_origin_input;
      logic origin_input;
      logic encoder_index_input;
   } hserr_sens_s;

   localparam int SENS_W = $bits(hserr_sens_s);

endpackage

//--- core/hserr_sync.sv
`timescale 1ns/1ps
module hserr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;
endmodule // hserr_sync

//--- core/hserr_core.sv
// What this block does
// - Drive fault in any step stops pulses instantly, ends search, sets fault flags.
// - Emergency stop in any step stops pulses instantly, ends search, sets flags.
// - Overrun limit in step three stops, ends search, sets matching limit flag.
// - Overrun limit in step four ends offset and search, sets limit flag.
// - Index already active at step three start ends search with index flag.
// - Any abnormal end sets the axis error bit in the main status.
// - Near-origin already active at step one start skips straight to step two.
// - Step one ended by forward limit continues with reverse form of step two.
// - Step two reverses on forward limit; opposite limit then ends with flag.
// - Step three forward limit before index edge ends search with limit flag.
// - Step three stops on index inactive-to-active transition, not level.
// - Near-origin, origin and index polarity come from input mode bits.
// - Input enable bits are ignored during the search.
// - Index flag clears on next drive, search or status clear command.
// - Busy bit stays one from step one start until step four ends.
// - Decelerating or instant stop command suspends step and ends search.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module hserr_core (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [2:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   input wire hserr_pkg::hserr_sens_s sens_in,
   input wire logic offset_done_in,
   input wire logic motion_idle_in,
   output logic drive_out,
   output logic dir_minus_out,
   output logic high_speed_out,
   output logic decel_out,
   output logic pos_clear_out
);
   hserr_pkg::hserr_sens_s sens;
   hserr_pkg::hserr_state_e state_r, state_nxt;
   logic [15:0] mode_r, inmode_r, cfg_r;
   logic [7:0] err_r, err_nxt, err_set, err_clr;
   logic [4:0] exec_r, exec_nxt;
   logic idx_prev_r, s3_first_r, s3_first_nxt;
   logic drive_r, dir_r, hs_r, decel_r, pclr_r, pclr_nxt;
   logic [15:0] rdata_r, rdata_nxt;

   hserr_sync #(.WIDTH(hserr_pkg::SENS_W)) u_sync (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .async_in(sens_in),
      .sync_out(sens)
   );

   // Active levels; enable bits of the input mode register are not consulted.
   // polarity from mode
   wire near_act = sens.near_origin_input ~^ inmode_r[hserr_pkg::POL_NEAR];
   wire org_act = sens.origin_input ~^ inmode_r[hserr_pkg::POL_ORIGIN];
   wire idx_act = sens.encoder_index_input ~^ inmode_r[hserr_pkg::POL_INDEX];
   wire idx_edge = idx_act & ~idx_prev_r;

   wire cmd_wr = wr_in && (addr_in == hserr_pkg::OFS_CMD);
   wire [7:0] cmd = wdata_in[7:0];
   wire cmd_search = cmd_wr && (cmd == hserr_pkg::CMD_SEARCH);
   wire cmd_dec = cmd_wr && (cmd == hserr_pkg::CMD_DEC_STOP);
   wire cmd_inst = cmd_wr && (cmd == hserr_pkg::CMD_INST_STOP);
   wire cmd_clr = cmd_wr && (cmd == hserr_pkg::CMD_CLR_STATUS);
   wire cmd_drive = cmd_wr && (cmd >= hserr_pkg::CMD_DRIVE_LO) && (cmd <= hserr_pkg::CMD_DRIVE_HI);

   wire [3:0] step_en = {mode_r[6], mode_r[4], mode_r[2], mode_r[0]};
   wire [3:0] step_dir = {mode_r[7], mode_r[5], mode_r[3], mode_r[1]};
   wire lim_inst = cfg_r[hserr_pkg::CFG_LIM_INST];
   wire busy = (state_r != hserr_pkg::ST_IDLE);

   // Direction of the current state, one meaning minus.
   wire reverse = (state_r == hserr_pkg::ST_S2_REV_FIND) || (state_r == hserr_pkg::ST_S2_REV_LEAVE);
   wire cur_dir = (state_r == hserr_pkg::ST_S1) ? step_dir[0] :
                  (state_r == hserr_pkg::ST_S3) ? step_dir[2] :
                  (state_r == hserr_pkg::ST_S4) ? step_dir[3] : (step_dir[1] ^ reverse);
   wire lim_fwd = cur_dir ? sens.minus_overrun_limit : sens.plus_overrun_limit;
   wire [7:0] lim_bit = cur_dir ? (8'h01 << hserr_pkg::ST2_MINUS) : (8'h01 << hserr_pkg::ST2_PLUS);
   wire [7:0] any_lim_bits = ({7'h00, sens.minus_overrun_limit} << hserr_pkg::ST2_MINUS) |
                             ({7'h00, sens.plus_overrun_limit} << hserr_pkg::ST2_PLUS);
   wire any_lim = sens.minus_overrun_limit | sens.plus_overrun_limit;

   // First enabled step at or after the given one; idle means normal completion.
   function automatic hserr_pkg::hserr_state_e first_step(input logic [1:0] k,
                                                           input logic [3:0] en);
      hserr_pkg::hserr_state_e s;
      s = hserr_pkg::ST_IDLE;
      if (en[3] && k <= 2'h3) s = hserr_pkg::ST_S4;
      if (en[2] && k <= 2'h2) s = hserr_pkg::ST_S3;
      if (en[1] && k <= 2'h1) s = hserr_pkg::ST_S2_FIND;
      if (en[0] && k == 2'h0) s = hserr_pkg::ST_S1;
      return s;
   endfunction

   // Step sequencing with faults first, then stop commands, then step events.
   always_comb begin
      state_nxt = state_r;
      err_set = 8'h00;
      pclr_nxt = 1'b0;
      if (state_r == hserr_pkg::ST_IDLE) begin
         if (cmd_search) begin
            state_nxt = first_step(2'h0, step_en);
         end
      end else if (sens.alarm) begin
         state_nxt = hserr_pkg::ST_IDLE;
         err_set[hserr_pkg::ST2_ALARM] = 1'b1;
      end else if (sens.emergency_stop_input) begin
         state_nxt = hserr_pkg::ST_IDLE;
         err_set[hserr_pkg::ST2_EMG] = 1'b1;
      end else if (state_r == hserr_pkg::ST_STOPPING) begin
         if (motion_idle_in || cmd_inst) state_nxt = hserr_pkg::ST_IDLE;
      end else if (cmd_inst) begin
         state_nxt = hserr_pkg::ST_IDLE;
      end else if (cmd_dec) begin
         state_nxt = hserr_pkg::ST_STOPPING;
      end else begin
         unique case (state_r)
            hserr_pkg::ST_S1: begin
               if (near_act) state_nxt = first_step(2'h1, step_en);
               else if (lim_fwd) state_nxt = step_en[1] ? hserr_pkg::ST_S2_REV_FIND :
                                                          first_step(2'h2, step_en);
            end
            hserr_pkg::ST_S2_FIND: begin
               if (org_act) state_nxt = first_step(2'h2, step_en);
               else if (lim_fwd) state_nxt = hserr_pkg::ST_S2_REV_FIND;
            end
            hserr_pkg::ST_S2_REV_FIND, hserr_pkg::ST_S2_REV_LEAVE: begin
               if (lim_fwd) begin
                  state_nxt = lim_inst ? hserr_pkg::ST_IDLE : hserr_pkg::ST_STOPPING;
                  err_set = lim_bit;
               end else if (state_r == hserr_pkg::ST_S2_REV_FIND) begin
                  if (org_act) state_nxt = hserr_pkg::ST_S2_REV_LEAVE;
               end else if (!org_act) begin
                  state_nxt = hserr_pkg::ST_S2_FIND;
               end
            end
            hserr_pkg::ST_S3: begin
               if (s3_first_r && idx_act) begin
                  state_nxt = hserr_pkg::ST_IDLE;
                  err_set[hserr_pkg::ST2_INDEX] = 1'b1;
               end else if (any_lim) begin
                  state_nxt = lim_inst ? hserr_pkg::ST_IDLE : hserr_pkg::ST_STOPPING;
                  err_set = any_lim_bits;
               end else if (idx_edge && !s3_first_r) begin
                  state_nxt = first_step(2'h3, step_en);
               end
            end
            hserr_pkg::ST_S4: begin
               if (any_lim) begin
                  state_nxt = lim_inst ? hserr_pkg::ST_IDLE : hserr_pkg::ST_STOPPING;
                  err_set = any_lim_bits;
               end else if (offset_done_in) begin
                  state_nxt = hserr_pkg::ST_IDLE;
                  pclr_nxt = mode_r[hserr_pkg::MODE_PCLR];
               end
            end
            default: state_nxt = hserr_pkg::ST_IDLE;
         endcase
      end
   end

   assign err_clr = (cmd_clr ? 8'hFF : 8'h00) |
                    ((cmd_search && !busy) || cmd_drive ? (8'h01 << hserr_pkg::ST2_INDEX) : 8'h00);
   // A fault flag raised in the same cycle as a clear survives it.
   assign err_nxt = (err_r & ~err_clr & ~((cmd_search && !busy) ? 8'hFF : 8'h00)) | err_set;

   assign exec_nxt = (state_nxt == hserr_pkg::ST_STOPPING) ? exec_r :
                     (state_nxt == hserr_pkg::ST_S1) ? hserr_pkg::EX_S1 :
                     (state_nxt == hserr_pkg::ST_S2_REV_FIND) ? hserr_pkg::EX_S2_REV_FIND :
                     (state_nxt == hserr_pkg::ST_S2_REV_LEAVE) ? hserr_pkg::EX_S2_REV_LEAVE :
                     (state_nxt == hserr_pkg::ST_S2_FIND) ? hserr_pkg::EX_S2_FIND :
                     (state_nxt == hserr_pkg::ST_S3) ? hserr_pkg::EX_S3 :
                     (state_nxt == hserr_pkg::ST_S4) ? hserr_pkg::EX_S4 : hserr_pkg::EX_IDLE;
   assign s3_first_nxt = (state_nxt == hserr_pkg::ST_S3) && (state_r != hserr_pkg::ST_S3);

   wire nxt_rev = (state_nxt == hserr_pkg::ST_S2_REV_FIND) ||
                  (state_nxt == hserr_pkg::ST_S2_REV_LEAVE);
   wire dir_nxt = (state_nxt == hserr_pkg::ST_S1) ? step_dir[0] :
                  (state_nxt == hserr_pkg::ST_S3) ? step_dir[2] :
                  (state_nxt == hserr_pkg::ST_S4) ? step_dir[3] :
                  (state_nxt == hserr_pkg::ST_STOPPING) ? dir_r : (step_dir[1] ^ nxt_rev);

   wire err_any = |err_r;
   wire [15:0] main_v = ({15'h0000, busy} << hserr_pkg::MAIN_BUSY) |
                        ({15'h0000, err_any} << hserr_pkg::MAIN_ERR);
   wire [15:0] st1_v = ({15'h0000, err_r[hserr_pkg::ST2_EMG]} << hserr_pkg::ST1_EMG) |
                       ({15'h0000, err_r[hserr_pkg::ST2_ALARM]} << hserr_pkg::ST1_ALARM) |
                       ({15'h0000, err_r[hserr_pkg::ST2_MINUS]} << hserr_pkg::ST1_MINUS) |
                       ({15'h0000, err_r[hserr_pkg::ST2_PLUS]} << hserr_pkg::ST1_PLUS);
   wire [15:0] st2_v = {3'h0, exec_r, err_r};
   assign rdata_nxt = !rd_in ? 16'h0000 :
                      (addr_in == hserr_pkg::OFS_MODE) ? mode_r :
                      (addr_in == hserr_pkg::OFS_INMODE) ? inmode_r :
                      (addr_in == hserr_pkg::OFS_CFG) ? cfg_r :
                      (addr_in == hserr_pkg::OFS_MAIN) ? main_v :
                      (addr_in == hserr_pkg::OFS_ST1) ? st1_v :
                      (addr_in == hserr_pkg::OFS_ST2) ? st2_v : 16'h0000;

   // Mode registers are only writable while idle so a running search stays coherent.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         mode_r <= hserr_pkg::MODE_RST;
         inmode_r <= hserr_pkg::INMODE_RST;
         cfg_r <= hserr_pkg::CFG_RST;
      end else if (wr_in && !busy) begin
         if (addr_in == hserr_pkg::OFS_MODE) mode_r <= wdata_in;
         if (addr_in == hserr_pkg::OFS_INMODE) inmode_r <= wdata_in;
         if (addr_in == hserr_pkg::OFS_CFG) cfg_r <= wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state_r <= hserr_pkg::ST_IDLE;
         err_r <= 8'h00;
         exec_r <= hserr_pkg::EX_IDLE;
         idx_prev_r <= 1'b0;
         s3_first_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         err_r <= err_nxt;
         exec_r <= exec_nxt;
         idx_prev_r <= idx_act;
         s3_first_r <= s3_first_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs are registered from the next-state decode so they track state_r exactly.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         drive_r <= 1'b0;
         dir_r <= 1'b0;
         hs_r <= 1'b0;
         decel_r <= 1'b0;
         pclr_r <= 1'b0;
      end else begin
         drive_r <= (state_nxt != hserr_pkg::ST_IDLE);
         dir_r <= dir_nxt;
         hs_r <= (state_nxt == hserr_pkg::ST_S1) || (state_nxt == hserr_pkg::ST_S4);
         decel_r <= (state_nxt == hserr_pkg::ST_STOPPING);
         pclr_r <= pclr_nxt;
      end
   end

   assign rdata_out = rdata_r;
   assign drive_out = drive_r;
   assign dir_minus_out = dir_r;
   assign high_speed_out = hs_r;
   assign decel_out = decel_r;
   assign pos_clear_out = pclr_r;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   a_alarm_stops: assert property (busy && sens.alarm |=> !drive_out && err_r[hserr_pkg::ST2_ALARM])
      else $error("Drive fault did not stop the search.");
   a_emg_stops: assert property (busy && !sens.alarm && sens.emergency_stop_input
                                 |=> state_r == hserr_pkg::ST_IDLE && err_r[hserr_pkg::ST2_EMG])
      else $error("Emergency stop did not end the search.");
   a_s3_limit: assert property (state_r == hserr_pkg::ST_S3 && !sens.alarm && !sens.emergency_stop_input
                                && !cmd_wr && !(s3_first_r && idx_act) && any_lim
                                |=> state_r != hserr_pkg::ST_S4
                                && (err_r & $past(any_lim_bits)) != 8'h00)
      else $error("Step three limit not handled.");
   a_s4_limit: assert property (state_r == hserr_pkg::ST_S4 && !sens.alarm && !sens.emergency_stop_input
                                && !cmd_wr && any_lim |=> !pos_clear_out && $changed(state_r))
      else $error("Step four limit not handled.");
   a_index_early: assert property (state_r == hserr_pkg::ST_S3 && s3_first_r && idx_act
                                   && !sens.alarm && !sens.emergency_stop_input && !cmd_wr
                                   |=> state_r == hserr_pkg::ST_IDLE && main_v[hserr_pkg::MAIN_ERR])
      else $error("Index already active not flagged.");
   a_err_main: assert property (rd_in && addr_in == hserr_pkg::OFS_MAIN && err_r != 8'h00
                                |=> rdata_out[hserr_pkg::MAIN_ERR])
      else $error("Main error bit missing.");
   a_busy_drive: assert property (busy && $past(busy) |-> drive_out)
      else $error("Drive output dropped while busy.");
   a_inst_cmd: assert property (busy && cmd_inst |=> state_r == hserr_pkg::ST_IDLE && !drive_out)
      else $error("Instant stop command ignored.");
   a_idx_clear: assert property (err_r[hserr_pkg::ST2_INDEX] && cmd_clr && !err_set[hserr_pkg::ST2_INDEX]
                                 |=> !err_r[hserr_pkg::ST2_INDEX])
      else $error("Index flag not cleared.");
   a_s1_near: assert property (state_r == hserr_pkg::ST_S1 && near_act && !sens.alarm
                               && !sens.emergency_stop_input && !cmd_wr
                               |=> state_r != hserr_pkg::ST_S1)
      else $error("Step one not skipped on near origin.");
endmodule // hserr_core

//--- test/hserr_sensor_model.sv
`timescale 1ns/1ps
module hserr_sensor_model #(
   parameter int IDLE_LAG = 8
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire hserr_pkg::hserr_sens_s pins_in,
   input wire logic offset_go_in,
   input wire logic decel_in,
   output hserr_pkg::hserr_sens_s sens_out,
   output logic offset_done_out,
   output logic motion_idle_out
);
   logic [3:0] lag_r;
   logic [3:0] lag_nxt;
   assign lag_nxt = (decel_in && lag_r != 4'hF) ? lag_r + 4'h1 : (decel_in ? lag_r : 4'h0);
   // Sensor levels held long.
   // The pins change only just after an edge, as a physical sensor seen through wiring would.
   always_ff @(posedge ref_clk_in) begin
      sens_out <= pins_in;
   end
   // A slow motor: deceleration takes several cycles, so a decelerating stop is seen waiting.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         lag_r <= 4'h0;
         offset_done_out <= 1'h0;
         motion_idle_out <= 1'h0;
      end else begin
         lag_r <= lag_nxt;
         offset_done_out <= offset_go_in;
         // The motor reports standstill only after the deceleration has run its course.
         motion_idle_out <= decel_in && (int'(lag_r) >= IDLE_LAG);
      end
   end
endmodule // hserr_sensor_model

//--- test/hserr_core_tb.sv
`timescale 1ns/1ps
module hserr_core_tb;
   logic ref_clk = 1'h0;
   logic resetn = 1'h0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic [15:0] rdata;
   hserr_pkg::hserr_sens_s pins = 7'h07;
   hserr_pkg::hserr_sens_s sens;
   logic offset_go = 1'h0;
   logic offset_done, motion_idle, drive, dir_minus, high_speed, decel, pos_clear;
   int n_errors = 0;
   int checks = 0;
   int n_clr = 0;
   int i;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (pos_clear === 1'h1) n_clr++;
   hserr_core u_hserr_core (.ref_clk_in(ref_clk), .resetn_in(resetn), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr_en), .rd_in(rd_en), .rdata_out(rdata), .sens_in(sens),
      .offset_done_in(offset_done), .motion_idle_in(motion_idle), .drive_out(drive),
      .dir_minus_out(dir_minus), .high_speed_out(high_speed), .decel_out(decel),
      .pos_clear_out(pos_clear));
   hserr_sensor_model #(.IDLE_LAG(8)) u_hserr_sensor_model (.ref_clk_in(ref_clk),
      .resetn_in(resetn), .pins_in(pins), .offset_go_in(offset_go), .decel_in(decel),
      .sens_out(sens), .offset_done_out(offset_done), .motion_idle_out(motion_idle));
   task summarize;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task cy(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'h1;
      @(posedge ref_clk);
      wr_en <= 1'h0;
   endtask
   task rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge ref_clk);
      rd_en <= 1'h0;
      #1;
      chk(n, e, rdata & m);
   endtask
   task wait_stop;
      for (i = 0; i < 200 && drive !== 1'h0; i++) @(posedge ref_clk);
      if (drive !== 1'h0) begin
         n_errors++;
         $display("unexpected drive_out expected 0 seen %b", drive);
         summarize();
      end
      cy(2);
   endtask
   // Search from idle; step one is skipped when p holds near-origin active.
   task start(input logic [15:0] mode, input logic [15:0] cfg, input hserr_pkg::hserr_sens_s p);
      pins <= p;
      wr(hserr_pkg::OFS_CFG, cfg);
      wr(hserr_pkg::OFS_MODE, mode);
      wr(hserr_pkg::OFS_CMD, {8'h00, hserr_pkg::CMD_SEARCH});
      cy(6);
   endtask
   task set_pin(input logic [6:0] m, input logic v);
      pins <= v ? (pins | m) : (pins & ~m);
      cy(6);
   endtask
   initial begin
      cy(12);
      resetn <= 1'h1;
      rd(hserr_pkg::OFS_MAIN, 16'hFFFF, 16'h0000, "main_reset");
      rd(hserr_pkg::OFS_ST2, 16'hFFFF, 16'h0000, "st2_reset");
      rd(3'h7, 16'hFFFF, 16'h0000, "unmapped");
      wr(hserr_pkg::OFS_INMODE, 16'h002A);
      start(16'h0155, 16'h0000, 7'h03);
      rd(hserr_pkg::OFS_ST2, 16'h1F00, 16'h0F00, "exec_s2");
      rd(hserr_pkg::OFS_MAIN, 16'h0100, 16'h0100, "busy_run");
      set_pin(7'h02, 1'h0);
      rd(hserr_pkg::OFS_ST2, 16'h1F00, 16'h1400, "exec_s3");
      set_pin(7'h01, 1'h0);
      rd(hserr_pkg::OFS_ST2, 16'h1F00, 16'h1900, "exec_s4");
      chk("high_speed", 16'h0001, {15'h0, high_speed});
      @(posedge ref_clk) offset_go <= 1'h1;
      @(posedge ref_clk) offset_go <= 1'h0;
      wait_stop();
      chk("pos_clear", 16'h0001, n_clr[15:0]);
      // Error bits read only after the search ended.
      rd(hserr_pkg::OFS_MAIN, 16'h0110, 16'h0000, "main_ok");
      $display("test normal done");
      // Drive command first, then the status clear command.
      for (int k = 0; k < 2; k++) begin
         start(16'h0055, 16'h0000, 7'h02);
         set_pin(7'h02, 1'h0);
         wait_stop();
         rd(hserr_pkg::OFS_ST2, 16'h0080, 16'h0080, "idx_flag");
         rd(hserr_pkg::OFS_MAIN, 16'h0010, 16'h0010, "main_err");
         wr(hserr_pkg::OFS_CMD,
            {8'h00, k == 0 ? hserr_pkg::CMD_DRIVE_LO : hserr_pkg::CMD_CLR_STATUS});
         rd(hserr_pkg::OFS_ST2, 16'h0080, 16'h0000, "idx_clr");
      end
      $display("test index done");
      for (int k = 0; k < 2; k++) begin
         start(16'h0055, 16'h0000, 7'h03);
         pins <= pins | (k == 0 ? 7'h40 : 7'h20);
         // Model stage, two sync stages and the output register: four edges, look after them.
         cy(5);
         chk("drive_fault", 16'h0000, {15'h0, drive});
         pins <= 7'h07;
         rd(hserr_pkg::OFS_ST2, 16'h1F30, k == 0 ? 16'h0010 : 16'h0020, "st2_fault");
         rd(hserr_pkg::OFS_ST1, 16'hC000, k == 0 ? 16'h4000 : 16'h8000, "st1_fault");
         rd(hserr_pkg::OFS_MAIN, 16'h0110, 16'h0010, "main_fault");
      end
      $display("test faults done");
      start(16'h0055, 16'h0001, 7'h03);
      set_pin(7'h02, 1'h0);
      pins <= pins | 7'h10;
      cy(5);
      chk("drive_lim3", 16'h0000, {14'h0, drive, decel});
      pins <= 7'h07;
      rd(hserr_pkg::OFS_ST2, 16'h000C, 16'h0004, "st2_lim3");
      rd(hserr_pkg::OFS_ST1, 16'h3000, 16'h1000, "st1_lim3");
      start(16'h0055, 16'h0000, 7'h03);
      set_pin(7'h02, 1'h0);
      set_pin(7'h01, 1'h0);
      pins <= pins | 7'h08;
      cy(5);
      chk("decel_lim4", 16'h0001, {15'h0, decel});
      wait_stop();
      pins <= 7'h07;
      rd(hserr_pkg::OFS_ST2, 16'h000C, 16'h0008, "st2_lim4");
      $display("test limits done");
      start(16'h0005, 16'h0000, 7'h07);
      set_pin(7'h10, 1'h1);
      rd(hserr_pkg::OFS_ST2, 16'h1F00, 16'h0800, "exec_rev");
      chk("dir_rev", 16'h0001, {15'h0, dir_minus});
      pins <= 7'h0F;
      wait_stop();
      pins <= 7'h07;
      rd(hserr_pkg::OFS_ST2, 16'h000C, 16'h0008, "st2_rev");
      rd(hserr_pkg::OFS_MAIN, 16'h0010, 16'h0010, "main_rev");
      $display("test reverse done");
      for (int k = 0; k < 2; k++) begin
         start(16'h0055, 16'h0000, 7'h03);
         wr(hserr_pkg::OFS_CMD, {8'h00, k == 0 ? hserr_pkg::CMD_DEC_STOP : hserr_pkg::CMD_INST_STOP});
         cy(1);
         chk("decel_cmd", k == 0 ? 16'h0001 : 16'h0000, {15'h0, decel});
         wait_stop();
         rd(hserr_pkg::OFS_ST2, 16'h1F00, 16'h0000, "exec_stop");
      end
      chk("pos_kept", 16'h0001, n_clr[15:0]);
      $display("test stops done");
      summarize();
   end
endmodule // hserr_core_tb
